// file: sync_tx_pkg.sv
// Package: register map, field positions and encodings for the sync transmitter
package sync_tx_pkg;
  // Register byte addresses on the AXI4-Lite bus
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_RX_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_LINE_MODE = 8'h10;
  localparam logic [7:0] ADDR_TX_CTRL = 8'h14;
  localparam logic [7:0] ADDR_SYNC_LOW = 8'h18;
  localparam logic [7:0] ADDR_SYNC_HIGH = 8'h1c;
  localparam logic [7:0] ADDR_MASTER_RESET = 8'h24;
  localparam logic [7:0] ADDR_SYNC_CRC_MISC = 8'h28;
  localparam logic [7:0] ADDR_TX_DATA = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h34;
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Command register: bits 7:6 code
  localparam int CMD_CODE_HI = 7;
  localparam int CMD_CODE_LO = 6;
  localparam logic [1:0] CMD_RESET_TX_CRC = 2'h2;
  // Master reset register: bits 7:6, any non-zero code resets the channel
  localparam int MRST_HI = 7;
  localparam int MRST_LO = 6;
  // Line mode register fields
  localparam int LM_PAR_EN = 0;
  localparam int LM_PAR_EVEN = 1;
  localparam int LM_STOP_LO = 2;
  localparam int LM_STOP_HI = 3;
  localparam int LM_SYNC_A = 4;
  localparam int LM_SYNC_B = 5;
  localparam int LM_CLK_LO = 6;
  localparam int LM_CLK_HI = 7;
  // Receive control register fields
  localparam int RC_RX_EN = 0;
  localparam int RC_AUTO_EN = 5;
  localparam int RC_LEN_LO = 6;
  localparam int RC_LEN_HI = 7;
  // Transmit control register fields
  localparam int TC_CRC_EN = 0;
  localparam int TC_RTS = 1;
  localparam int TC_CRC16 = 2;
  localparam int TC_TX_EN = 3;
  localparam int TC_LEN_LO = 5;
  localparam int TC_LEN_HI = 6;
  // Sync/CRC misc register fields
  localparam int SM_SYNC6 = 0;
  localparam int SM_PRESET = 7;
  // Character length codes to bit counts
  localparam logic [1:0] LEN_CODE_5 = 2'h0;
  localparam logic [1:0] LEN_CODE_7 = 2'h1;
  localparam logic [1:0] LEN_CODE_6 = 2'h2;
  localparam logic [4:0] BITS_5 = 5'h05;
  localparam logic [4:0] BITS_6 = 5'h06;
  localparam logic [4:0] BITS_7 = 5'h07;
  localparam logic [4:0] BITS_8 = 5'h08;
  localparam logic [4:0] BITS_16 = 5'h10;
  // CRC polynomials, bit-reversed for LSB-first shifting
  localparam logic [15:0] POLY_CRC16 = 16'ha001;
  localparam logic [15:0] POLY_CCITT = 16'h8408;
  localparam logic [15:0] CRC_ONES = 16'hffff;
  localparam logic [15:0] CRC_ZEROS = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Status register bit positions
  localparam int ST_BUF_EMPTY = 0;
  localparam int ST_ALL_SENT = 1;
  localparam int ST_CTS = 2;
  localparam int ST_TX_ACTIVE = 3;
  localparam int ST_CRC_LO = 16;
  typedef enum logic [2:0] {
    TX_MARK = 3'b001,
    TX_DATA = 3'b010,
    TX_SYNC = 3'b100
  } tx_state_t;
endpackage : sync_tx_pkg

// file: byte_sync_serial_transmitter.sv
// Byte-synchronous serial transmitter with AXI4-Lite register access
// Contract
// R1 - Enable bits set last, after configuration
// R2 - Initialisation starts with master reset bits
// R3 - One line-mode write configures both directions
// R4 - Receive control holds length, auto enables
// R5 - Transmit control: length and request-to-send
// R6 - Six-bit sync uses low six bits
// R7 - Eight-bit sync sends low sync byte
// R8 - Sixteen-bit sync sends low then high
// R9 - Transmitter sync six/eight in external mode
// R10 - Clock mode forced zero outside external sync
// R11 - Both sync bits select external sync
// R12 - Sync low/high registers hold sync bytes
// R13 - Data right-justified, upper bits ignored
// R14 - Optional parity bit after data bits
// R15 - Polynomial select: CRC-16 or CCITT
// R16 - Preset bit chooses ones or zeros
// R17 - CRC reset only by software command
// R18 - CRC only when enabled, never sync
// R19 - CRC enable sampled at buffer load
// R20 - Request-to-send pin is inverted bit
// R21 - Clear-to-send gates transmitter under auto enables
// R22 - Empty buffer sends sync back to back
`timescale 1ns/100ps
`default_nettype none
module byte_sync_serial_transmitter (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [sync_tx_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sync_tx_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txc,
  input wire logic cts_n,
  output logic txd,
  output logic rts_n
);
  import sync_tx_pkg::*;

  logic [7:0] line_mode_reg, rx_ctrl_reg, tx_ctrl_reg;
  logic [7:0] sync_low_reg, sync_high_reg, misc_reg, tx_buf_reg;
  logic buf_full_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [7:0] awaddr_reg, wdata_reg;
  logic wstrb0_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic txc_s1_reg, txc_s2_reg, txc_s3_reg;
  logic cts_s1_reg, cts_s2_reg;
  logic txd_reg, rts_n_reg;
  // Serial engine state
  tx_state_t state_reg, state_next;
  logic [16:0] shift_reg, shift_next;
  logic [4:0] bits_left_reg, bits_left_next;
  logic [4:0] crc_bits_reg, crc_bits_next;
  logic crc_char_reg, crc_char_next;
  logic [15:0] crc_reg, crc_next;

  // Write decode
  // Only byte lane 0 carries a register; a write with that lane masked is answered, then dropped
  wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire wr_lane = do_write && wstrb0_reg;
  wire wr_cmd = wr_lane && (awaddr_reg == ADDR_COMMAND);
  wire wr_rxc = wr_lane && (awaddr_reg == ADDR_RX_CTRL);
  wire wr_lm = wr_lane && (awaddr_reg == ADDR_LINE_MODE);
  wire wr_txc = wr_lane && (awaddr_reg == ADDR_TX_CTRL);
  wire wr_sl = wr_lane && (awaddr_reg == ADDR_SYNC_LOW);
  wire wr_sh = wr_lane && (awaddr_reg == ADDR_SYNC_HIGH);
  wire wr_mr = wr_lane && (awaddr_reg == ADDR_MASTER_RESET);
  wire wr_misc = wr_lane && (awaddr_reg == ADDR_SYNC_CRC_MISC);
  wire wr_data = wr_lane && (awaddr_reg == ADDR_TX_DATA);
  wire wr_mapped = (awaddr_reg == ADDR_COMMAND) || (awaddr_reg == ADDR_RX_CTRL)
    || (awaddr_reg == ADDR_LINE_MODE) || (awaddr_reg == ADDR_TX_CTRL)
    || (awaddr_reg == ADDR_SYNC_LOW) || (awaddr_reg == ADDR_SYNC_HIGH)
    || (awaddr_reg == ADDR_MASTER_RESET) || (awaddr_reg == ADDR_SYNC_CRC_MISC)
    || (awaddr_reg == ADDR_TX_DATA);
  // Master reset: channel or hardware reset clears all configuration
  wire chan_rst = wr_mr && (wdata_reg[MRST_HI:MRST_LO] != 2'h0); // see R2
  wire crc_cmd = wr_cmd && (wdata_reg[CMD_CODE_HI:CMD_CODE_LO] == CMD_RESET_TX_CRC);

  // Mode decode
  // Stop bits select async framing, which this block lacks: the loader then stays idle
  wire async_mode = (line_mode_reg[LM_STOP_HI:LM_STOP_LO] != 2'h0); // see R3 R10
  wire ext_sync = line_mode_reg[LM_SYNC_A] && line_mode_reg[LM_SYNC_B]; // see R11
  wire sync6 = misc_reg[SM_SYNC6];
  // Clock mode only matters in external sync; elsewhere it reads as zero
  wire [1:0] clk_mode = ext_sync ? line_mode_reg[LM_CLK_HI:LM_CLK_LO] : 2'h0; // see R10
  wire sync16 = line_mode_reg[LM_SYNC_A] && !line_mode_reg[LM_SYNC_B] && !sync6; // see R8
  wire [4:0] sync_bits = sync16 ? BITS_16 : (sync6 ? BITS_6 : BITS_8); // see R6 R7 R9
  wire [15:0] sync_pat = sync16 ? {sync_high_reg, sync_low_reg} // see R12
    : (sync6 ? {10'h000, sync_low_reg[5:0]} : {8'h00, sync_low_reg});
  wire auto_en = rx_ctrl_reg[RC_AUTO_EN]; // see R4
  // With auto enables on, a high clear-to-send pin (line inactive) holds the transmitter off
  wire tx_enabled = tx_ctrl_reg[TC_TX_EN] && !(auto_en && cts_s2_reg); // see R1 R21
  wire [1:0] len_code = tx_ctrl_reg[TC_LEN_HI:TC_LEN_LO]; // see R5
  wire [4:0] char_bits = (len_code == LEN_CODE_5) ? BITS_5 : (len_code == LEN_CODE_7) ? BITS_7
    : (len_code == LEN_CODE_6) ? BITS_6 : BITS_8;
  // Bits above the character length are dropped
  wire [7:0] char_mask = 8'hff >> (4'h8 - char_bits[3:0]); // see R13
  wire [7:0] char_data = tx_buf_reg & char_mask;
  wire par_en = line_mode_reg[LM_PAR_EN];
  wire par_bit = line_mode_reg[LM_PAR_EVEN] ? (^char_data) : ~(^char_data); // see R14
  wire [16:0] par_shifted = {16'h0000, par_bit} << char_bits;
  wire [16:0] data_word = {9'h000, char_data} | (par_en ? par_shifted : 17'h00000);
  wire [4:0] data_bits = char_bits + {4'h0, par_en};
  wire [15:0] poly = tx_ctrl_reg[TC_CRC16] ? POLY_CRC16 : POLY_CCITT; // see R15
  wire [15:0] crc_preset = misc_reg[SM_PRESET] ? CRC_ONES : CRC_ZEROS; // see R16
  // Transmit clock falling edge: the line changes on it
  wire txc_fall = txc_s3_reg && !txc_s2_reg;
  wire char_done = (bits_left_reg <= 5'h01);
  wire crc_fb = shift_reg[0] ^ crc_reg[0];
  wire [15:0] crc_step = {1'b0, crc_reg[15:1]} ^ (crc_fb ? poly : 16'h0000);
  wire crc_bit_now = crc_char_reg && (state_reg == TX_DATA) && (crc_bits_reg != 5'h00);
  wire load_now = txc_fall && char_done && !async_mode;
  wire take_buf = load_now && tx_enabled && buf_full_reg;

  // Read decode; status flags are plain levels, nothing clears on read
  wire buf_empty = !buf_full_reg;
  // All sent also waits for the last data bit, so software knows when to drop the line
  wire all_sent = buf_empty && (state_reg != TX_DATA);
  wire tx_active = (state_reg != TX_MARK);
  wire [31:0] status_word = {crc_reg, 12'h000, tx_active, cts_s2_reg, all_sent, buf_empty};
  wire [31:0] rd_mux =
    (s_axi_araddr == ADDR_RX_CTRL) ? {24'h000000, rx_ctrl_reg} :
    (s_axi_araddr == ADDR_LINE_MODE) ? {24'h000000, line_mode_reg[7:6] & clk_mode,
      line_mode_reg[5:0]} :
    (s_axi_araddr == ADDR_TX_CTRL) ? {24'h000000, tx_ctrl_reg} :
    (s_axi_araddr == ADDR_SYNC_LOW) ? {24'h000000, sync_low_reg} :
    (s_axi_araddr == ADDR_SYNC_HIGH) ? {24'h000000, sync_high_reg} :
    (s_axi_araddr == ADDR_SYNC_CRC_MISC) ? {24'h000000, misc_reg} :
    (s_axi_araddr == ADDR_STATUS) ? status_word : 32'h00000000;
  wire rd_mapped = (s_axi_araddr == ADDR_RX_CTRL) || (s_axi_araddr == ADDR_LINE_MODE)
    || (s_axi_araddr == ADDR_TX_CTRL) || (s_axi_araddr == ADDR_SYNC_LOW)
    || (s_axi_araddr == ADDR_SYNC_HIGH) || (s_axi_araddr == ADDR_SYNC_CRC_MISC)
    || (s_axi_araddr == ADDR_STATUS);

  // Serial engine next state
  // Loads happen only at a character boundary, so a mode change never cuts a character
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bits_left_next = bits_left_reg;
    crc_bits_next = crc_bits_reg;
    crc_char_next = crc_char_reg;
    crc_next = crc_reg;
    if (txc_fall) begin
      if (crc_bit_now) begin
        crc_next = crc_step; // see R18
        crc_bits_next = crc_bits_reg - 5'h01;
      end
      shift_next = {1'b1, shift_reg[16:1]};
      bits_left_next = (bits_left_reg == 5'h00) ? 5'h00 : bits_left_reg - 5'h01;
      if (load_now) begin
        if (take_buf) begin
          state_next = TX_DATA;
          shift_next = data_word;
          bits_left_next = data_bits;
          crc_bits_next = char_bits;
          crc_char_next = tx_ctrl_reg[TC_CRC_EN]; // see R19
        end else if (tx_enabled) begin
          // Idle fill is sync, never counted in the CRC
          state_next = TX_SYNC; // see R22
          shift_next = {1'b0, sync_pat};
          bits_left_next = sync_bits;
          crc_bits_next = 5'h00;
          crc_char_next = 1'b0; // see R18
        end else begin
          state_next = TX_MARK;
          shift_next = {17{1'b1}};
          bits_left_next = 5'h00;
          crc_char_next = 1'b0;
        end
      end
    end
    // The CRC is only ever preset by command
    // A command beats a same-cycle CRC bit: software asked for a fresh start
    if (crc_cmd) begin
      crc_next = crc_preset; // see R17
    end
  end

  // Pin synchronisers; the link clock drifts freely against ref_clk
  // A third stage on the bit clock yields a clean falling-edge strobe at one cycle's cost
  // The bit clock must stay well below half of ref_clk for every edge to be seen
  always_ff @(posedge ref_clk) begin
    txc_s1_reg <= txc;
    txc_s2_reg <= txc_s1_reg;
    txc_s3_reg <= txc_s2_reg;
    cts_s1_reg <= cts_n;
    cts_s2_reg <= cts_s1_reg;
  end

  // Configuration registers
  // Nothing here orders the setup: software must set the enable bits last
  always_ff @(posedge ref_clk) begin
    if (rst || chan_rst) begin
      line_mode_reg <= REG_RESET;
      rx_ctrl_reg <= REG_RESET;
      tx_ctrl_reg <= REG_RESET;
      sync_low_reg <= REG_RESET;
      sync_high_reg <= REG_RESET;
      misc_reg <= REG_RESET;
    end else begin
      if (wr_lm) line_mode_reg <= wdata_reg; // see R3
      if (wr_rxc) rx_ctrl_reg <= wdata_reg; // see R4
      if (wr_txc) tx_ctrl_reg <= wdata_reg; // see R5
      if (wr_sl) sync_low_reg <= wdata_reg; // see R12
      if (wr_sh) sync_high_reg <= wdata_reg;
      if (wr_misc) misc_reg <= wdata_reg;
    end
  end

  // Transmit buffer: a new write wins over the load that empties it
  // Writing a full buffer overwrites the waiting byte; poll buffer empty first
  always_ff @(posedge ref_clk) begin
    if (rst || chan_rst) begin
      buf_full_reg <= 1'b0;
      tx_buf_reg <= REG_RESET;
    end else begin
      if (wr_data) tx_buf_reg <= wdata_reg;
      if (wr_data) buf_full_reg <= 1'b1;
      else if (take_buf) buf_full_reg <= 1'b0;
    end
  end

  // Serial engine registers; a disabled transmitter still finishes its character
  always_ff @(posedge ref_clk) begin
    if (rst || chan_rst) begin
      state_reg <= TX_MARK;
      shift_reg <= {17{1'b1}};
      bits_left_reg <= 5'h00;
      crc_bits_reg <= 5'h00;
      crc_char_reg <= 1'b0;
      crc_reg <= CRC_ZEROS;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bits_left_reg <= bits_left_next;
      crc_bits_reg <= crc_bits_next;
      crc_char_reg <= crc_char_next;
      crc_reg <= crc_next;
    end
  end

  // Output pins
  // Both pins come straight from flops so decode never glitches the line
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txd_reg <= 1'b1;
      rts_n_reg <= 1'b1;
    end else begin
      // A channel reset marks the line at once rather than finishing the character
      txd_reg <= chan_rst ? 1'b1 : shift_next[0];
      rts_n_reg <= ~(chan_rst ? 1'b0 : (wr_txc ? wdata_reg[TC_RTS] : tx_ctrl_reg[TC_RTS])); // see R20
    end
  end

  // AXI4-Lite write channel
  // Address and data may come in either order; each ready drops once its beat is held
  // and returns only with the response, so one write at most is ever in flight
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
        wready_reg <= 1'b0;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  // The read mux looks at the live address, so data is captured on the taking edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign txd = txd_reg;
  assign rts_n = rts_n_reg;
endmodule : byte_sync_serial_transmitter
`default_nettype wire

// file: byte_sync_serial_transmitter_asserts.sv
// Checker: bus handshake and line timing of the sync transmitter
`timescale 1ns/100ps
`default_nettype none
module sync_tx_checker
  import sync_tx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sync_tx_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txd,
  input wire logic rts_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  reset_idle_a: assert property ($fell(rst) |-> txd && rts_n)
    else $error("line not idle after reset");
  bit_hold_a: assert property ($changed(txd) |=> $stable(txd) [*6])
    else $error("serial bit too short");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr == ADDR_COMMAND |=> s_axi_rresp == RESP_SLVERR)
    else $error("write-only read without error");
  write_release_a: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not reopened");
  read_release_a: assert property (s_axi_rvalid && s_axi_rready
      |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not reopened");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted before response");
endmodule : sync_tx_checker
`default_nettype wire

// file: sync_line_partner.sv
// Partner: remote synchronous station giving bit clock and clear-to-send
`timescale 1ns/100ps
`default_nettype none
module sync_line_partner (
  input wire logic txd,
  input wire logic cts_req,
  output logic txc,
  output logic cts_n,
  output logic [31:0] cap
);
  // A synchronous link clocks all the time, idle sync included
  initial begin
    txc = 1'b0;
    #37;
    forever #200 txc = ~txc;
  end
  assign cts_n = ~cts_req;
  // Sample at the fall: the line moves under three ref_clk cycles later, well clear of it
  initial cap = 32'hffffffff;
  always @(negedge txc) cap <= {txd, cap[31:1]};
endmodule : sync_line_partner
`default_nettype wire

// file: tb_byte_sync_serial_transmitter.sv
// Testbench: register programming and serial line checks
`timescale 1ns/100ps
`default_nettype none
module tb_byte_sync_serial_transmitter;
  import sync_tx_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic cts_req = 1'b1;
  wire logic awready, wready, bvalid, arready, rvalid, txc, cts_n, txd, rts_n;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata, cap;
  int fail_count = 0;
  int checks = 0;
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  byte_sync_serial_transmitter i_byte_sync_serial_transmitter (
    .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .txc(txc), .cts_n(cts_n), .txd(txd), .rts_n(rts_n));
  sync_line_partner i_sync_line_partner (
    .txd(txd), .cts_req(cts_req), .txc(txc), .cts_n(cts_n), .cap(cap));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stall(input int n);
    if (n > 60) begin
      check("bus answer", 32'h0, 32'h1);
      complete_run();
    end
  endtask : stall
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    logic [1:0] r;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      stall(n);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      r = bresp;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("write response", {30'h0, r}, {30'h0, er});
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    logic [1:0] r;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      stall(n);
      if (arready === 1'b1) arvalid <= 1'b0;
      d = rdata;
      r = rresp;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check("read response", {30'h0, r}, {30'h0, er});
    @(posedge ref_clk);
  endtask : rd
  task automatic bits(input int n);
    repeat (n * 8) @(posedge ref_clk);
  endtask : bits
  // Pattern of n bits anywhere in the window, optionally framed by mark bits
  function automatic logic [31:0] has(input logic [31:0] c, input logic [15:0] p,
      input int n, input logic edges);
    logic [31:0] hit;
    hit = 32'h0;
    for (int i = 0; i + n < 32; i++) begin
      if (((c >> i) & ((32'h1 << n) - 1)) === {16'h0, p}
          && (!edges || (c[i - 1] && c[i + n]))) hit = 32'h1;
    end
    return hit;
  endfunction : has
  function automatic logic [31:0] periodic(input logic [31:0] c, input int n);
    logic [31:0] ok;
    ok = 32'h1;
    for (int i = 0; i + n < 32; i++) begin
      if (c[i] !== c[i + n]) ok = 32'h0;
    end
    return ok;
  endfunction : periodic
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [15:0] p,
      input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ p) : (c >> 1);
    end
    return c;
  endfunction : crc_byte
  task automatic t_regs();
    logic [31:0] d;
    check("idle line", {30'h0, txd, rts_n}, 32'h3);
    wr(ADDR_MASTER_RESET, 8'hc0);
    wr(8'h3c, 8'h55, RESP_SLVERR);
    rd(8'h3c, d, RESP_SLVERR);
    check("unmapped data", d, 32'h0);
    rd(ADDR_COMMAND, d, RESP_SLVERR);
    wr(ADDR_LINE_MODE, 8'hc4);
    rd(ADDR_LINE_MODE, d);
    check("forced clock mode", d, 32'h04);
    wr(ADDR_LINE_MODE, 8'h30);
    rd(ADDR_LINE_MODE, d);
    check("external sync mode", d, 32'h30);
    wstrb <= 4'h0;
    wr(ADDR_LINE_MODE, 8'h00);
    wstrb <= 4'h1;
    rd(ADDR_LINE_MODE, d);
    check("masked lane write", d, 32'h30);
    wr(ADDR_TX_CTRL, 8'h02);
    check("request to send on", {31'h0, rts_n}, 32'h0);
    wr(ADDR_TX_CTRL, 8'h00);
    check("request to send off", {31'h0, rts_n}, 32'h1);
    $display("register test done");
  endtask : t_regs
  task automatic t_sync();
    logic [7:0] lm [5] = '{8'h00, 8'h00, 8'h10, 8'h30, 8'h30};
    logic [7:0] sm [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h01};
    int per [5] = '{6, 8, 16, 8, 6};
    logic [15:0] pat [5] = '{16'h0016, 16'h00d6, 16'h69d6, 16'h00d6, 16'h0016};
    wr(ADDR_SYNC_LOW, 8'hd6);
    wr(ADDR_SYNC_HIGH, 8'h69);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_TX_CTRL, 8'h00);
      wr(ADDR_LINE_MODE, lm[i]);
      wr(ADDR_SYNC_CRC_MISC, sm[i]);
      wr(ADDR_TX_CTRL, 8'h68);
      bits(56);
      check("sync period", periodic(cap, per[i]), 32'h1);
      check("sync pattern", has(cap, pat[i], per[i], 1'b0), 32'h1);
    end
    $display("sync test done");
  endtask : t_sync
  task automatic t_data();
    logic [7:0] lm [3] = '{8'h03, 8'h01, 8'h00};
    logic [7:0] tc [3] = '{8'h68, 8'h68, 8'h08};
    logic [7:0] dat [3] = '{8'h5b, 8'h5b, 8'h43};
    logic [15:0] fr [3] = '{16'h015b, 16'h005b, 16'h0003};
    int n [3] = '{9, 9, 5};
    wr(ADDR_SYNC_LOW, 8'hff);
    wr(ADDR_SYNC_CRC_MISC, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_TX_CTRL, 8'h00);
      wr(ADDR_LINE_MODE, lm[i]);
      wr(ADDR_TX_CTRL, tc[i]);
      bits(20);
      wr(ADDR_TX_DATA, dat[i]);
      bits(24);
      check("framed character", has(cap, fr[i], n[i], 1'b1), 32'h1);
    end
    $display("data test done");
  endtask : t_data
  task automatic t_crc();
    logic [7:0] tc [2] = '{8'h6d, 8'h69};
    logic [7:0] sm [2] = '{8'h00, 8'h80};
    logic [15:0] poly [2] = '{POLY_CRC16, POLY_CCITT};
    logic [15:0] pre [2] = '{CRC_ZEROS, CRC_ONES};
    logic [31:0] d;
    logic [15:0] e;
    e = 16'h0;
    wr(ADDR_LINE_MODE, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_SYNC_CRC_MISC, sm[i]);
      wr(ADDR_TX_CTRL, tc[i]);
      bits(10);
      rd(ADDR_STATUS, d);
      if (i == 1) check("crc kept", {16'h0, d[31:16]}, {16'h0, e});
      wr(ADDR_COMMAND, 8'h80);
      rd(ADDR_STATUS, d);
      check("crc preset", {16'h0, d[31:16]}, {16'h0, pre[i]});
      e = crc_byte(pre[i], poly[i], 8'ha5);
      wr(ADDR_TX_DATA, 8'ha5);
      bits(24);
      rd(ADDR_STATUS, d);
      check("crc of data", {16'h0, d[31:16]}, {16'h0, e});
      wr(ADDR_TX_CTRL, tc[i] & 8'hfe);
      wr(ADDR_TX_DATA, 8'h3c);
      bits(24);
      rd(ADDR_STATUS, d);
      check("crc of excluded data", {16'h0, d[31:16]}, {16'h0, e});
    end
    $display("crc test done");
  endtask : t_crc
  task automatic t_auto();
    wr(ADDR_SYNC_LOW, 8'hd6);
    wr(ADDR_TX_CTRL, 8'h68);
    wr(ADDR_RX_CTRL, 8'he1);
    cts_req <= 1'b0;
    bits(40);
    check("held by clear-to-send", cap, 32'hffffffff);
    cts_req <= 1'b1;
    bits(40);
    check("resumed sync", has(cap, 16'h00d6, 8, 1'b0), 32'h1);
    $display("auto enable test done");
  endtask : t_auto
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_sync();
    t_data();
    t_crc();
    t_auto();
    complete_run();
  end
endmodule : tb_byte_sync_serial_transmitter
bind byte_sync_serial_transmitter sync_tx_checker i_sync_tx_checker (
  .ref_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd, .rts_n);
`default_nettype wire
